// ### rtl/sef_flags.sv
// Event flag registers, acknowledge handling and interrupt pulse
// generator of the pressure sensor, with its client serial port.
// Assumes event inputs are one-cycle pulses on i_clk; the serial clock
// is a separate domain that only toggles inside a chip-select frame.
`timescale 1ns/1ps

module sef_flags
  import sef_pkg::*;
#(
  parameter int P_SHORT_CYCLES = SEF_SHORT_PULSE_CYC,
  parameter int P_LONG_CYCLES  = SEF_LONG_PULSE_CYC
) (
  // Core clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Client serial port (link clock domain)
  input  wire logic       i_spi_sck,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_mosi,
  output logic            o_spi_miso,
  output logic            o_spi_miso_oe,
  // Threshold events
  input  wire logic       i_slope_limit_event,
  input  wire logic       i_relative_limit_event,
  input  wire logic       i_fixed_limit_event,
  // Verification and self-test outcomes
  input  wire logic       i_fw_check_done,
  input  wire logic       i_fw_check_error,
  input  wire logic       i_cell_selftest_done,
  input  wire logic       i_cell_selftest_error,
  input  wire logic       i_converter_selftest_done,
  input  wire logic       i_converter_selftest_error,
  // Acquisition outcome
  input  wire logic       i_acquisition_done,
  input  wire logic [7:0] i_acquisition_errors,
  // Trigger configuration
  input  wire logic       i_fw_error_trigger_enable,
  input  wire logic       i_selftest_error_trigger_enable,
  input  wire logic       i_sensor_error_trigger_enable,
  input  wire logic       i_data_ready_trigger_enable,
  input  wire logic       i_pulse_polarity_select,
  input  wire logic       i_pulse_length_select,
  // Interrupt pin
  output logic            o_int_pin
);

  ////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    logic [7:0]                 exec_status;
    logic [7:0]                 acq_error;
    logic                       ack_pending;
    logic [7:0]                 snap_exec;
    logic [7:0]                 snap_acq;
    logic                       snap_ack;
    logic [2:0]                 cs_sync;
    logic                       cs_idle;
    logic [2:0]                 ack_sync;
    logic                       ack_seen;
    logic                       pulse_active;
    logic [SEF_PULSE_CNT_W-1:0] pulse_cnt;
    logic                       int_pin;
  } sef_core_type;

  typedef struct packed {
    logic [7:0] rx_shift;
    logic [3:0] bit_cnt;
    logic       first_done;
    logic       is_read;
    logic [6:0] addr;
    logic [7:0] tx_byte;
  } sef_link_type;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } sef_out_type;

  // Core state holds both flag registers and everything that decides
  // when they clear. The acknowledge arrives from the serial side as a
  // toggle, so a single write is seen exactly once however slow or fast
  // the serial clock runs against the core clock.
  // The snapshot copies exist so the link side reads bytes that cannot
  // change under an open frame: a flag set mid-frame shows up in the
  // next frame instead of tearing a byte across two shift edges.
  // The pulse counter is loaded with the pulse length less one and runs
  // down to zero, so the pin stands active for exactly the chosen count.
  // Link state lives in its own struct because it is clocked by the
  // serial clock and cleared by an idle chip select, not by i_rst.
  // The output struct is clocked on the falling serial edge so that data
  // is stable across the rising edge where the host samples it.
  sef_core_type core_reg;
  sef_core_type core_next;
  sef_link_type link_reg;
  sef_link_type link_next;
  sef_out_type  out_reg;
  sef_out_type  out_next;
  logic         ack_toggle_reg;
  logic         ack_toggle_next;

  localparam logic [SEF_PULSE_CNT_W-1:0] SHORT_LAST =
    SEF_PULSE_CNT_W'(P_SHORT_CYCLES - 1);
  localparam logic [SEF_PULSE_CNT_W-1:0] LONG_LAST =
    SEF_PULSE_CNT_W'(P_LONG_CYCLES - 1);
  localparam logic [SEF_PULSE_CNT_W-1:0] CNT_ZERO = '0;

  ////////////////////////////////////////////////////////////////////////
  // Core domain: flag setting, acknowledge, pulse generation

  logic [7:0] exec_set;
  logic       fire;
  logic       acq_faulty;
  logic       ack_event;
  logic       ack_clear;

  // Event decode into status bits and a pulse request
  always_comb begin
    exec_set   = '0;
    fire       = 1'b0;
    acq_faulty = |i_acquisition_errors;
    if (i_slope_limit_event) begin
      exec_set[SEF_SLOPE_LIMIT_BIT] = 1'b1;
      fire = 1'b1;
    end
    if (i_relative_limit_event) begin
      exec_set[SEF_RELATIVE_LIMIT_BIT] = 1'b1;
      fire = 1'b1;
    end
    if (i_fixed_limit_event) begin
      exec_set[SEF_FIXED_LIMIT_BIT] = 1'b1;
      fire = 1'b1;
    end
    if (i_fw_check_done && i_fw_check_error) begin
      exec_set[SEF_FW_CHECK_FAIL_BIT] = 1'b1;
      fire = fire | i_fw_error_trigger_enable;
    end
    if (i_cell_selftest_done && i_cell_selftest_error) begin
      exec_set[SEF_CELL_SELFTEST_BIT] = 1'b1;
      fire = fire | i_selftest_error_trigger_enable;
    end
    if (i_converter_selftest_done && i_converter_selftest_error) begin
      exec_set[SEF_CONV_SELFTEST_BIT] = 1'b1;
      fire = fire | i_selftest_error_trigger_enable;
    end
    if (i_acquisition_done) begin
      if (acq_faulty) begin
        exec_set[SEF_ACQUISITION_BIT] = 1'b1;
        fire = fire | i_sensor_error_trigger_enable
                    | i_data_ready_trigger_enable;
      end else begin
        fire = fire | i_data_ready_trigger_enable;
      end
    end
    exec_set[SEF_PULSE_RAISED_BIT] = fire;
  end

  // The acknowledge toggle is taken through three flops; a change counts
  // only once the second and third stages agree, which filters a flop
  // that went metastable on the sampling edge.
  // Chip select is synchronised the same way; the clear waits for the
  // synchronised idle level so that it always lands after the frame
  // that carried the acknowledge has ended, as the host expects.
  // Holding the request in ack_pending lets the command byte read back
  // as set until the clear has really happened.
  // Hazard: if chip select never rises, the clear never happens; the
  // flags then stay latched, which is the safe direction.
  // Acknowledge arrives as a toggle; clear waits for an idle frame
  assign ack_event = (core_reg.ack_sync[1] == core_reg.ack_sync[2]) &&
                     (core_reg.ack_sync[2] != core_reg.ack_seen);
  assign ack_clear = core_reg.ack_pending && core_reg.cs_idle;

  // Next core state
  always_comb begin
    core_next = core_reg;
    // Synchronisers: first stage feeds only the second
    core_next.cs_sync  = {core_reg.cs_sync[1:0], i_spi_cs_n};
    core_next.ack_sync = {core_reg.ack_sync[1:0], ack_toggle_reg};
    if (core_reg.cs_sync[1] == core_reg.cs_sync[2]) begin
      core_next.cs_idle = core_reg.cs_sync[2];
    end
    if (ack_event) begin
      core_next.ack_seen    = core_reg.ack_sync[2];
      core_next.ack_pending = 1'b1;
    end
    // Latched flags; new events win over a clear in the same cycle
    if (ack_clear) begin
      core_next.exec_status = exec_set;
      core_next.acq_error   = '0;
      core_next.ack_pending = ack_event;
    end else begin
      core_next.exec_status = core_reg.exec_status | exec_set;
    end
    if (i_acquisition_done) begin
      core_next.acq_error = core_next.acq_error | i_acquisition_errors;
    end
    // Snapshot for the link is frozen while a frame is open
    if (core_reg.cs_idle) begin
      core_next.snap_exec = core_reg.exec_status;
      core_next.snap_acq  = core_reg.acq_error;
      core_next.snap_ack  = core_reg.ack_pending;
    end
    // The pin is computed from the next pulse state so it changes on the
    // same edge that takes the event, with no extra cycle of delay.
    // A firing event during a pulse reloads the counter, so back to back
    // events give one longer pulse rather than a gap the host could miss.
    // Polarity is read live; it is meant to change only while idle.
    // Pulse timer; a new event restarts the pulse
    if (fire) begin
      core_next.pulse_active = 1'b1;
      core_next.pulse_cnt = i_pulse_length_select ? LONG_LAST
                                                  : SHORT_LAST;
    end else if (core_reg.pulse_active) begin
      if (core_reg.pulse_cnt == CNT_ZERO) begin
        core_next.pulse_active = 1'b0;
      end else begin
        core_next.pulse_cnt = core_reg.pulse_cnt - 1'b1;
      end
    end
    core_next.int_pin = core_next.pulse_active ? i_pulse_polarity_select
                                               : ~i_pulse_polarity_select;
    if (i_rst) begin
      core_next             = '0;
      core_next.exec_status = SEF_EXEC_STATUS_RST;
      core_next.acq_error   = SEF_ACQ_ERROR_RST;
      core_next.cs_sync     = '1;
      core_next.cs_idle     = 1'b1;
      core_next.int_pin     = ~i_pulse_polarity_select;
    end
  end

  // Core register
  always_ff @(posedge i_clk) begin
    core_reg <= core_next;
  end

  assign o_int_pin = core_reg.int_pin;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: frame shifter, cleared whenever chip select is high
  //
  // A frame is a command byte (read flag and address) followed by data
  // bytes, most significant bit first, sampled on the rising serial
  // clock. The read byte is chosen as the last command bit arrives, so
  // the mux decodes the address straight from the incoming shift word.
  // Writes decode only the acknowledge bit of the command register;
  // every other written byte is dropped, since both flag registers are
  // read-only. A partial byte is lost when chip select rises early.
  // Because chip select clears the frame state asynchronously, the
  // serial clock need not run outside frames.

  logic [7:0] rx_full;
  logic [7:0] read_data;

  // Read multiplexer over the quasi-static snapshot
  always_comb begin
    read_data = SEF_READ_IDLE;
    case (rx_full[6:0])
      SEF_ADDR_EXEC_STATUS: read_data = core_reg.snap_exec;
      SEF_ADDR_ACQ_ERROR:   read_data = core_reg.snap_acq;
      SEF_ADDR_COMMAND:
        read_data[SEF_ACK_COMMAND_BIT] = core_reg.snap_ack;
      default:              read_data = SEF_READ_IDLE;
    endcase
  end

  assign rx_full = {link_reg.rx_shift[6:0], i_spi_mosi};

  // Next link state on each rising serial clock
  always_comb begin
    link_next          = link_reg;
    ack_toggle_next    = ack_toggle_reg;
    link_next.rx_shift = rx_full;
    link_next.bit_cnt  = link_reg.bit_cnt + 1'b1;
    if (link_reg.bit_cnt == SEF_LAST_BIT) begin
      link_next.bit_cnt = '0;
      if (!link_reg.first_done) begin
        link_next.first_done = 1'b1;
        link_next.is_read    = rx_full[SEF_RW_BIT];
        link_next.addr       = rx_full[6:0];
      end else if (!link_reg.is_read &&
                   link_reg.addr == SEF_ADDR_COMMAND &&
                   rx_full[SEF_ACK_COMMAND_BIT]) begin
        ack_toggle_next = ~ack_toggle_reg;
      end
    end
    if (link_reg.bit_cnt == SEF_LAST_BIT && !link_reg.first_done) begin
      link_next.tx_byte = read_data;
    end else if (link_reg.bit_cnt == SEF_LAST_BIT) begin
      link_next.tx_byte = SEF_READ_IDLE;
    end
  end

  // Frame state, cleared asynchronously by an idle chip select
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // Acknowledge toggle survives between frames
  always_ff @(posedge i_spi_sck or posedge i_rst) begin
    if (i_rst) begin
      ack_toggle_reg <= 1'b0;
    end else begin
      ack_toggle_reg <= ack_toggle_next;
    end
  end

  // The data line is driven from the first falling edge of a frame and
  // released to zero with its enable low as soon as chip select rises.
  // During the command byte it shifts out zeros, since no read data
  // exists yet. The bit index counts down from the top of the byte so
  // the first falling edge after the command byte shows bit 7.
  // Data out changes on falling serial clock, most significant first
  always_comb begin
    out_next.miso_oe = 1'b1;
    out_next.miso    = link_reg.tx_byte[SEF_LAST_BIT[2:0] -
                                        link_reg.bit_cnt[2:0]];
  end

  // Output driver register
  always_ff @(negedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign o_spi_miso    = out_reg.miso;
  assign o_spi_miso_oe = out_reg.miso_oe;

endmodule

// ### rtl/sef_pkg.sv
// Constants shared by the sensor event flag block.
// Assumes a 200 MHz core clock and a mode-0 client serial port.
package sef_pkg;

  // Register byte addresses (7-bit address field on the serial port)
  localparam logic [6:0] SEF_ADDR_EXEC_STATUS = 7'h55;
  localparam logic [6:0] SEF_ADDR_ACQ_ERROR   = 7'h56;
  localparam logic [6:0] SEF_ADDR_COMMAND     = 7'h57;

  // Reset values of the flag registers and the idle read byte
  localparam logic [7:0] SEF_EXEC_STATUS_RST  = 8'h00;
  localparam logic [7:0] SEF_ACQ_ERROR_RST    = 8'h00;
  localparam logic [7:0] SEF_READ_IDLE        = 8'h00;

  // Execution status field positions
  localparam int SEF_PULSE_RAISED_BIT      = 7;
  localparam int SEF_SLOPE_LIMIT_BIT       = 6;
  localparam int SEF_RELATIVE_LIMIT_BIT    = 5;
  localparam int SEF_FIXED_LIMIT_BIT       = 4;
  localparam int SEF_FW_CHECK_FAIL_BIT     = 3;
  localparam int SEF_CELL_SELFTEST_BIT     = 2;
  localparam int SEF_CONV_SELFTEST_BIT     = 1;
  localparam int SEF_ACQUISITION_BIT       = 0;

  // Command register: acknowledge bit
  localparam int SEF_ACK_COMMAND_BIT       = 7;

  // Serial frame layout: first byte = read flag + address, then data
  localparam int         SEF_RW_BIT        = 7;
  localparam logic [3:0] SEF_BYTE_BITS     = 4'h8;
  localparam logic [3:0] SEF_LAST_BIT      = 4'h7;

  // Interrupt pulse lengths
  localparam int SEF_SHORT_PULSE_MS        = 4;
  localparam int SEF_LONG_PULSE_MS         = 8;
  localparam int SEF_CLK_KHZ               = 200000;
  localparam int SEF_SHORT_PULSE_CYC       = SEF_SHORT_PULSE_MS * SEF_CLK_KHZ;
  localparam int SEF_LONG_PULSE_CYC        = SEF_LONG_PULSE_MS * SEF_CLK_KHZ;
  localparam int SEF_PULSE_CNT_W           = 24;

endpackage

// ### tb/sef_flags_bench.sv
// Bench for the event flag block: events, flag reads, acknowledge, pin.
// Assumes the host model in sef_host and short pulse parameters.
`timescale 1ns/1ps
module sef_flags_bench;
  import sef_pkg::*;
  localparam int NS = 20;
  localparam int NL = 40;
  logic       i_clk = 1'b0, i_rst = 1'b1, pol = 1'b0, len = 1'b0;
  logic [6:0] dn = 7'h00; // Done strobes, indexed by status bit
  logic [7:0] ae = 8'h00;
  logic [3:0] en = 4'hf;  // fw, selftest, sensor, ready
  logic       sck, cs_n, mosi, miso, miso_oe, int_pin;
  logic [7:0] q;
  int         n_fail = 0, tests_run = 0;

  sef_flags #(.P_SHORT_CYCLES(NS), .P_LONG_CYCLES(NL)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .i_slope_limit_event(dn[6]), .i_relative_limit_event(dn[5]),
    .i_fixed_limit_event(dn[4]), .i_fw_check_done(dn[3]),
    .i_fw_check_error(|ae), .i_cell_selftest_done(dn[2]),
    .i_cell_selftest_error(|ae), .i_converter_selftest_done(dn[1]),
    .i_converter_selftest_error(|ae), .i_acquisition_done(dn[0]),
    .i_acquisition_errors(ae), .i_fw_error_trigger_enable(en[3]),
    .i_selftest_error_trigger_enable(en[2]),
    .i_sensor_error_trigger_enable(en[1]),
    .i_data_ready_trigger_enable(en[0]), .i_pulse_polarity_select(pol),
    .i_pulse_length_select(len), .o_int_pin(int_pin));
  sef_host host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

  // Core clock, 5 ns
  initial forever #2.5 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    host.xfer({1'b1, a, 8'h00}, q);
    check(q, exp);
    check({7'h00, miso_oe}, 8'h00);
  endtask
  task automatic ack;
    host.xfer({1'b0, SEF_ADDR_COMMAND, 8'h80}, q);
  endtask
  task automatic pin(input logic exp);
    check({7'h00, int_pin}, {7'h00, exp});
  endtask
  task automatic fire(input int k, input logic [7:0] e);
    @(posedge i_clk) #1 dn[k] = 1'b1;
    ae = e;
    @(posedge i_clk) #1 dn = 7'h00;
    ae = 8'h00;
  endtask
  task automatic reset_dut(input logic p);
    @(posedge i_clk) #1 i_rst = 1'b1;
    pol = p;
    len = p;
    repeat (20) @(posedge i_clk);
    #1 i_rst = 1'b0;
    pin(~p);
    repeat (5) @(posedge i_clk);
  endtask
  task automatic pulse_len(input int n);
    int c;
    c = 0;
    while (int_pin === pol && c < 100) begin
      c++;
      @(posedge i_clk) #1;
    end
    if (c >= 100) begin
      n_fail++;
      report_and_stop;
    end else check(8'(c), 8'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_dut(1'b0);
    rd(SEF_ADDR_EXEC_STATUS, 8'h00);
    rd(SEF_ADDR_ACQ_ERROR, 8'h00);
    host.xfer({1'b0, SEF_ADDR_EXEC_STATUS, 8'hff}, q);
    rd(SEF_ADDR_EXEC_STATUS, 8'h00);
    rd(7'h54, 8'h00);
    $display("test reset values done");
    // Each status event but acquisition alone, read twice, then acknowledged
    for (int k = 6; k >= 1; k--) begin
      fire(k, 8'h01);
      pin(pol);
      rd(SEF_ADDR_EXEC_STATUS, 8'h80 | (8'h01 << k));
      rd(SEF_ADDR_EXEC_STATUS, 8'h80 | (8'h01 << k));
      ack;
      rd(SEF_ADDR_EXEC_STATUS, 8'h00);
    end
    $display("test status events done");
    // Each acquisition error bit alone
    for (int i = 0; i < 8; i++) begin
      fire(0, 8'h01 << i);
      rd(SEF_ADDR_ACQ_ERROR, 8'h01 << i);
      rd(SEF_ADDR_EXEC_STATUS, 8'h81);
      ack;
      rd(SEF_ADDR_ACQ_ERROR, 8'h00);
      rd(SEF_ADDR_COMMAND, 8'h00);
    end
    $display("test acquisition errors done");
    // Triggers off: flags latch but the pin stays idle
    en = 4'h0;
    fire(3, 8'h01);
    pin(~pol);
    fire(0, 8'h02);
    pin(~pol);
    rd(SEF_ADDR_EXEC_STATUS, 8'h09);
    rd(SEF_ADDR_ACQ_ERROR, 8'h02);
    ack;
    en = 4'h1;
    fire(0, 8'h00);
    pin(pol);
    rd(SEF_ADDR_EXEC_STATUS, 8'h80);
    rd(SEF_ADDR_ACQ_ERROR, 8'h00);
    fire(2, 8'h00);
    rd(SEF_ADDR_EXEC_STATUS, 8'h80);
    $display("test trigger enables done");
    // Pulse length and polarity, both settings
    for (int p = 0; p < 2; p++) begin
      reset_dut(p[0]);
      fire(6, 8'h00);
      pulse_len((p == 1) ? NL : NS);
    end
    $display("test pulse shape done");
    report_and_stop;
  end
endmodule

// ### tb/sef_flags_sva.sv
// Checker for the event flag block: interrupt pin firing, length, idle.
// Assumes polarity and length select change only while reset is held.
`timescale 1ns/1ps
module sef_flags_sva
  import sef_pkg::*;
#(
  parameter int P_SHORT_CYCLES = SEF_SHORT_PULSE_CYC,
  parameter int P_LONG_CYCLES  = SEF_LONG_PULSE_CYC
) (
  // Clock and reset
  input wire logic       i_clk, i_rst,
  // Events and outcomes
  input wire logic       i_slope_limit_event, i_relative_limit_event,
  input wire logic       i_fixed_limit_event,
  input wire logic       i_fw_check_done, i_fw_check_error,
  input wire logic       i_cell_selftest_done, i_cell_selftest_error,
  input wire logic       i_converter_selftest_done,
  input wire logic       i_converter_selftest_error,
  input wire logic       i_acquisition_done,
  input wire logic [7:0] i_acquisition_errors,
  // Trigger configuration
  input wire logic       i_fw_error_trigger_enable,
  input wire logic       i_selftest_error_trigger_enable,
  input wire logic       i_sensor_error_trigger_enable,
  input wire logic       i_data_ready_trigger_enable,
  input wire logic       i_pulse_polarity_select, i_pulse_length_select,
  // Interrupt pin
  input wire logic       o_int_pin
);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Pin level, firing causes and the pulse length in force
  logic        act, st_ev, fire_ev;
  logic [23:0] lim, cnt_reg;
  assign act = (o_int_pin == i_pulse_polarity_select);
  assign st_ev = (i_cell_selftest_done && i_cell_selftest_error) ||
    (i_converter_selftest_done && i_converter_selftest_error);
  assign fire_ev = i_slope_limit_event || i_relative_limit_event ||
    i_fixed_limit_event || (st_ev && i_selftest_error_trigger_enable) ||
    (i_fw_check_done && i_fw_check_error && i_fw_error_trigger_enable) ||
    (i_acquisition_done && (i_data_ready_trigger_enable ||
    (i_sensor_error_trigger_enable && |i_acquisition_errors)));
  assign lim = i_pulse_length_select ? 24'(P_LONG_CYCLES)
                                     : 24'(P_SHORT_CYCLES);

  // Active cycles since the last firing cause; a new cause restarts it
  always_ff @(posedge i_clk) begin
    cnt_reg <= (i_rst || !act || fire_ev) ? 24'h000000 : cnt_reg + 24'h1;
  end

  property p_slope; i_slope_limit_event |=> act; endproperty
  a_slope: assert property (p_slope) else $error("slope no pulse");
  property p_rel; i_relative_limit_event |=> act; endproperty
  a_rel: assert property (p_rel) else $error("relative no pulse");
  property p_fix; i_fixed_limit_event |=> act; endproperty
  a_fix: assert property (p_fix) else $error("fixed no pulse");
  property p_fw;
    i_fw_check_done && i_fw_check_error && i_fw_error_trigger_enable |=> act;
  endproperty
  a_fw: assert property (p_fw) else $error("fw error no pulse");
  property p_st; st_ev && i_selftest_error_trigger_enable |=> act; endproperty
  a_st: assert property (p_st) else $error("selftest no pulse");
  property p_rdy; i_acquisition_done && i_data_ready_trigger_enable |=> act;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready no pulse");
  property p_sens; i_acquisition_done && |i_acquisition_errors &&
    i_sensor_error_trigger_enable |=> act; endproperty
  a_sens: assert property (p_sens) else $error("sensor no pulse");
  property p_quiet; !act && !fire_ev |=> !act; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse no cause");
  property p_len; act |-> cnt_reg < lim; endproperty
  a_len: assert property (p_len) else $error("pulse too long");
  property p_end; $fell(act) |-> $past(cnt_reg) == lim - 24'h1; endproperty
  a_end: assert property (p_end) else $error("pulse too short");
  property p_idle; $fell(i_rst) |-> !act; endproperty
  a_idle: assert property (p_idle) else $error("pin not idle");

  // Main scenarios reached
  c_long: cover property (act && i_pulse_length_select);
  c_end: cover property ($fell(act));
  c_err: cover property (i_acquisition_done && |i_acquisition_errors);
endmodule

bind sef_flags sef_flags_sva #(
  .P_SHORT_CYCLES(P_SHORT_CYCLES),
  .P_LONG_CYCLES (P_LONG_CYCLES)
) u_sva (.*);

// ### tb/sef_host.sv
// Host controller model on the client serial port, mode 0, 32 ns sck.
// Assumes one caller at a time; sck stands low outside frames.
`timescale 1ns/1ps
module sef_host (
  // Serial lines toward the device
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi,
  // Serial data from the device
  input  wire logic i_miso
);
  // Idle lines
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One frame: command byte then data byte, MSB first, read back byte two
  task automatic xfer(input logic [15:0] w, output logic [7:0] q);
    q = 8'h00;
    #7 o_cs_n = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #16 o_sck = 1'b1;
      if (i < 8) q[i] = i_miso;
      #16 o_sck = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line shows no stale value
    #100;
  endtask
endmodule
